// File: design/interpolator_position_output.sv
/*
  Digital output side of a sine/cosine tracking interpolator: angle
  counter, multiturn counter, incremental tracks, timing and errors.
  Assumes comparator, segment, index and strap inputs are asynchronous
  and the 8-bit register port is synchronous to core_clk.
*/
module interpolator_position_output
  import interp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       cmp_up,
  input  wire logic       cmp_down,
  input  wire logic [2:0] seg_in,
  input  wire logic       index_in,
  input  wire logic       undervolt_in,
  input  wire logic       sda_in,
  input  wire logic       scl_in,
  input  wire logic       multi_function_pin_in,
  output logic            multi_function_pin_out,
  output logic            multi_function_pin_oe,
  output logic            error_out_low_out,
  output logic            error_out_low_oe,
  output logic [7:0]      data_out,
  output logic [7:0]      data_oe,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata
);
  localparam int SYNC_W = 10;

  logic [SYNC_W-1:0] sync_bus;
  logic              up_s;
  logic              dn_s;
  logic [SEG_W-1:0]  seg_s;
  logic              index_s;
  logic              uv_s;
  logic              sda_s;
  logic              scl_s;
  logic              mfp_s;

  pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in ({multi_function_pin_in, scl_in, sda_in, undervolt_in,
                index_in, seg_in, cmp_down, cmp_up}),
    .sync_out (sync_bus)
  );
  assign {mfp_s, scl_s, sda_s, uv_s, index_s, seg_s, dn_s, up_s} = sync_bus;

  // Registers and state
  logic [7:0]        config_r;
  logic [2:0]        ctrl_r;
  logic [MT_W-1:0]   target;
  logic [ANG_W-1:0]  count;
  logic              up_q;
  logic              dn_q;
  logic              hold;
  logic [SEG_W-1:0]  seg_q;
  logic [ANG_W-1:0]  eff_prev;
  logic [MT_W-1:0]   mturn;
  logic              index_q;
  logic [ANG_W-1:0]  out_ang;
  logic [7:0]        gap;
  logic              dir;
  logic [TACH_W-1:0] ticks;
  logic [TACH_W-1:0] tacho;
  logic              err_uv;
  logic              err_ovs;
  logic [1:0]        strap_cnt;
  logic              strap_done;
  mode_e             mode;

  // Configuration decode
  wire [3:0] res_raw = config_r[CFG_RES_LSB +: 4];
  wire [3:0] res = (res_raw > RES_MAX) ? RES_MAX : res_raw;
  wire [3:0] shamt = RES_MAX - res;
  wire [ANG_W-1:0] res_mask = ~(8'hff >> res);
  wire [ANG_W-1:0] lsb = 8'h01 << shamt;
  wire [ANG_W-1:0] zero_off =
    {config_r[CFG_ZERO_LSB +: SEG_W], STEP_W'(0)};
  wire invert = config_r[CFG_INV];
  wire idx_clr_en = ctrl_r[CTL_IDX_CLR];
  wire mfp_is_out = ctrl_r[CTL_MFP_OUT];
  wire mfp_tgt = ctrl_r[CTL_MFP_TGT];

  // Tracking converter: two agreeing samples, then one idle cycle
  wire step_up = up_s & up_q & ~dn_s & ~hold;
  wire step_dn = dn_s & dn_q & ~up_s & ~hold;
  wire [SEG_W-1:0] seg_diff = seg_s - count[ANG_W-1 -: SEG_W];
  // Jump only on a settled segment code, to skip the slow walk
  wire seg_jump = (seg_s == seg_q) && (seg_diff != '0);
  wire [STEP_W-1:0] seg_entry =
    (seg_diff == SEG_NEXT) ? SEG_ENTER_UP :
    (seg_diff == SEG_PREV) ? SEG_ENTER_DN : SEG_ENTER_MID;

  // Effective angle: zero shift, then sense inversion
  wire [ANG_W-1:0] shifted = ANG_W'(count + zero_off);
  wire [ANG_W-1:0] eff = invert ? ANG_W'(8'h00 - shifted)
                                : shifted;
  wire [ANG_W-1:0] eff_q = eff & res_mask;

  // Period wrap drives the multiturn counter
  wire wrap_up = (eff_prev[7:6] == 2'b11) && (eff[7:6] == 2'b00);
  wire wrap_dn = (eff_prev[7:6] == 2'b00) && (eff[7:6] == 2'b11);
  wire index_rise = index_s & ~index_q;
  wire mt_clear = idx_clr_en & index_rise;
  wire gate_ok = mfp_is_out | mfp_s;

  // Output stepper, one lsb per edge gap
  wire [ANG_W-1:0] diff = ANG_W'(eff_q - out_ang);
  wire out_move = (gap == 8'h00) && (diff != '0);
  wire [ANG_W-1:0] next_out_ang =
    diff[ANG_W-1] ? ANG_W'(out_ang - lsb) : ANG_W'(out_ang + lsb);
  wire overspeed = (diff != '0) && (diff != lsb) &&
                   (diff != ANG_W'(8'h00 - lsb));
  wire [ANG_W-1:0] out_idx = out_ang >> shamt;
  wire [ANG_W-1:0] nidx = next_out_ang >> shamt;

  // Next incremental line values
  wire track_a_fine = out_idx[1];
  wire track_b_fine = out_idx[1] ^ out_idx[0];
  wire track_a_quad = out_ang[7];
  wire track_b_quad = out_ang[7] ^ out_ang[6];
  wire index_fine = index_s & (out_idx[1:0] == 2'b00);
  wire index_quad = index_s & (out_ang[7:6] == 2'b00);
  wire [7:0] next_data;
  assign next_data[DL_A_FINE] = track_a_fine;
  assign next_data[DL_B_FINE] = track_b_fine;
  assign next_data[DL_Z_FINE] = index_fine;
  assign next_data[DL_A_QUAD] = track_a_quad;
  assign next_data[DL_B_QUAD] = track_b_quad;
  assign next_data[DL_Z_QUAD] = index_quad;
  assign next_data[DL_DIR] = dir;
  assign next_data[DL_XOR] = track_a_fine ^ track_b_fine;
  wire unused_nidx = |nidx;

  // Register port decode
  wire wr_config = reg_wr && (reg_addr == ADDR_CONFIG);
  wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  wire wr_err = reg_wr && (reg_addr == ADDR_ERR);
  wire wr_t0 = reg_wr && (reg_addr == ADDR_TGT0);
  wire wr_t1 = reg_wr && (reg_addr == ADDR_TGT1);
  wire wr_t2 = reg_wr && (reg_addr == ADDR_TGT2);
  wire [7:0] rd_mux =
    (reg_addr == ADDR_CONFIG) ? config_r :
    (reg_addr == ADDR_CTRL)   ? {5'h00, ctrl_r} :
    (reg_addr == ADDR_ANGLE)  ? eff_q :
    (reg_addr == ADDR_MT0)    ? mturn[7:0] :
    (reg_addr == ADDR_MT1)    ? mturn[15:8] :
    (reg_addr == ADDR_MT2)    ? mturn[23:16] :
    (reg_addr == ADDR_TACH0)  ? tacho[7:0] :
    (reg_addr == ADDR_TACH1)  ? tacho[15:8] :
    (reg_addr == ADDR_ERR)    ? {6'h00, err_ovs, err_uv} :
    (reg_addr == ADDR_TGT0)   ? target[7:0] :
    (reg_addr == ADDR_TGT1)   ? target[15:8] :
    (reg_addr == ADDR_TGT2)   ? target[23:16] :
    (reg_addr == ADDR_STATUS) ? {4'h0, dir, mode} : 8'h00;
  // Set beats a same-cycle write-one clear
  wire next_err_uv = uv_s | (err_uv & ~(wr_err & reg_wdata[ERR_UV]));
  wire next_err_ovs = (overspeed & ~seg_jump) |
                      (err_ovs & ~(wr_err & reg_wdata[ERR_OVS]));
  wire strap_take = (strap_cnt == STRAP_WAIT) && !strap_done;
  wire [1:0] strap = {sda_s, scl_s};
  wire tick_max = &ticks;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      config_r <= CONFIG_RESET;
      ctrl_r <= '0;
      target <= '0;
    end else begin
      if (wr_config) config_r <= reg_wdata;
      if (wr_ctrl) ctrl_r <= reg_wdata[2:0];
      if (wr_t0) target[7:0] <= reg_wdata;
      if (wr_t1) target[15:8] <= reg_wdata;
      if (wr_t2) target[23:16] <= reg_wdata;
    end
  end

  // Angle counter; segment jump gives fast lock after reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count <= '0;
      up_q <= 1'b0;
      dn_q <= 1'b0;
      hold <= 1'b0;
      seg_q <= '0;
    end else begin
      up_q <= up_s;
      dn_q <= dn_s;
      seg_q <= seg_s;
      hold <= step_up | step_dn;
      if (seg_jump) begin
        count <= {seg_s, seg_entry};
      end else if (step_up) begin
        count <= ANG_W'(count + 8'h01);
      end else if (step_dn) begin
        count <= ANG_W'(count - 8'h01);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mturn <= '0;
      eff_prev <= '0;
      index_q <= 1'b0;
    end else begin
      eff_prev <= eff;
      index_q <= index_s;
      if (mt_clear) begin
        mturn <= '0;
      end else if (gate_ok && wrap_up) begin
        mturn <= MT_W'(mturn + 24'h000001);
      end else if (gate_ok && wrap_dn) begin
        mturn <= MT_W'(mturn - 24'h000001);
      end
    end
  end

  // Output stepper and tick counter
  always_ff @(posedge core_clk) begin
    if (reset) begin
      out_ang <= '0;
      gap <= '0;
      dir <= 1'b0;
      ticks <= '0;
      tacho <= '0;
    end else begin
      if (out_move) begin
        out_ang <= next_out_ang;
        dir <= diff[ANG_W-1];
        gap <= EDGE_GAP - 8'h01;
        tacho <= ticks;
        ticks <= '0;
      end else begin
        if (gap != 8'h00) gap <= gap - 8'h01;
        if (!tick_max) ticks <= ticks + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      err_uv <= 1'b0;
      err_ovs <= 1'b0;
      strap_cnt <= '0;
      strap_done <= 1'b0;
      mode <= MODE_PAR;
    end else begin
      err_uv <= next_err_uv;
      err_ovs <= next_err_ovs;
      if (!strap_done && strap_cnt != STRAP_WAIT) begin
        strap_cnt <= strap_cnt + 2'h1;
      end
      if (strap_take) begin
        strap_done <= 1'b1;
        unique case (strap)
          STRAP_SER: mode <= MODE_SER;
          STRAP_INC: mode <= MODE_INC;
          default:   mode <= MODE_PAR;
        endcase
      end
    end
  end

  // Registered pins
  always_ff @(posedge core_clk) begin
    if (reset) begin
      data_out <= '0;
      data_oe <= '0;
      multi_function_pin_out <= 1'b0;
      multi_function_pin_oe <= 1'b0;
      error_out_low_out <= 1'b0;
      error_out_low_oe <= 1'b0;
      reg_rdata <= '0;
    end else begin
      data_out <= next_data;
      data_oe <= (mode == MODE_INC) ? 8'hff : 8'h00;
      multi_function_pin_oe <= mfp_is_out;
      multi_function_pin_out <= mfp_tgt ? (mturn == target)
                                        : out_move;
      error_out_low_oe <= err_uv | err_ovs;
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_step;
    step_up || step_dn;
  endsequence

  sequence s_wrap_fwd;
    gate_ok && wrap_up && !mt_clear;
  endsequence

  a_step_spacing: assert property (
    s_step |=> !(step_up || step_dn))
    else $error("converter stepped on consecutive cycles");

  a_index_clear: assert property (
    mt_clear |=> (mturn == '0))
    else $error("index did not clear counter");

  a_gate_halt: assert property (
    (!gate_ok && !mt_clear) |=> $stable(mturn))
    else $error("counter moved while gated off");

  a_wrap_count: assert property (
    s_wrap_fwd |=> (mturn == MT_W'($past(mturn) + 24'h000001)))
    else $error("forward wrap did not increment counter");

  a_xor_line: assert property (
    data_oe[DL_XOR] |->
      (data_out[DL_XOR] == (data_out[DL_A_FINE] ^ data_out[DL_B_FINE])))
    else $error("xor line mismatch");

  a_edge_rate: assert property (
    $changed(data_out[1:0]) |=> $stable(data_out[1:0]) [*8])
    else $error("fine tracks changed too fast");

  a_error_pin: assert property (
    (uv_s && !err_uv) |=> ##1 error_out_low_oe)
    else $error("error pin not driven on undervoltage");

  a_strap_inc: assert property (
    (strap_take && strap == STRAP_INC) |=> (mode == MODE_INC) ##1
      (data_oe == 8'hff))
    else $error("incremental strap not honoured");

  a_seg_jump: assert property (
    seg_jump |=> (count[ANG_W-1 -: SEG_W] == $past(seg_s)))
    else $error("segment jump missed target segment");
endmodule : interpolator_position_output

// File: design/pin_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes inputs asynchronous to core_clk; output changes only when
  the second and third stages agree.
*/
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // First stage feeds only the second; stages run through reset so
  // the pin level is already settled when reset lifts
  always_ff @(posedge core_clk) begin
    stage1 <= async_in;
    stage2 <= stage1;
    stage3 <= stage2;
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (reset) begin
          sync_out[i] <= 1'b0;
        end else if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  endgenerate
endmodule : pin_sync

// File: inc/interp_pkg.sv
/*
  Constants for the interpolator position output block: register map,
  field positions, strap codes, access modes and timing counts.
  Assumes a 250 MHz core clock and an 8-bit register port.
*/
package interp_pkg;
  // Clock and incremental output timing
  localparam int CLK_KHZ      = 250000;
  localparam int INC_FREQ_KHZ = 400;
  // Four track edges per output period; least gap rounds up
  localparam int EDGE_GAP_INT =
    (CLK_KHZ + 4 * INC_FREQ_KHZ - 1) / (4 * INC_FREQ_KHZ);
  localparam logic [7:0] EDGE_GAP = 8'(EDGE_GAP_INT);

  // Angle geometry
  localparam int ANG_W  = 8;
  localparam int SEG_W  = 3;
  localparam int STEP_W = 5;
  localparam int MT_W   = 24;
  localparam int TACH_W = 16;
  localparam logic [3:0] RES_MAX      = 4'h8;
  localparam logic [4:0] SEG_ENTER_UP = 5'h00;
  localparam logic [4:0] SEG_ENTER_DN = 5'h1f;
  localparam logic [4:0] SEG_ENTER_MID = 5'h10;
  localparam logic [2:0] SEG_NEXT     = 3'h1;
  localparam logic [2:0] SEG_PREV     = 3'h7;

  // Register indices
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_CTRL   = 4'h1;
  localparam logic [3:0] ADDR_ANGLE  = 4'h2;
  localparam logic [3:0] ADDR_MT0    = 4'h3;
  localparam logic [3:0] ADDR_MT1    = 4'h4;
  localparam logic [3:0] ADDR_MT2    = 4'h5;
  localparam logic [3:0] ADDR_TACH0  = 4'h6;
  localparam logic [3:0] ADDR_TACH1  = 4'h7;
  localparam logic [3:0] ADDR_ERR    = 4'h8;
  localparam logic [3:0] ADDR_TGT0   = 4'h9;
  localparam logic [3:0] ADDR_TGT1   = 4'ha;
  localparam logic [3:0] ADDR_TGT2   = 4'hb;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  // CONFIG fields: resolution log2, zero shift, invert
  localparam int CFG_RES_LSB  = 0;
  localparam int CFG_ZERO_LSB = 4;
  localparam int CFG_INV      = 7;
  localparam logic [7:0] CONFIG_RESET = 8'h08;
  // CTRL fields
  localparam int CTL_IDX_CLR  = 0;
  localparam int CTL_MFP_OUT  = 1;
  localparam int CTL_MFP_TGT  = 2;
  // ERROR fields
  localparam int ERR_UV  = 0;
  localparam int ERR_OVS = 1;

  // Data line positions in incremental mode
  localparam int DL_A_FINE = 0;
  localparam int DL_B_FINE = 1;
  localparam int DL_Z_FINE = 2;
  localparam int DL_A_QUAD = 3;
  localparam int DL_B_QUAD = 4;
  localparam int DL_Z_QUAD = 5;
  localparam int DL_DIR    = 6;
  localparam int DL_XOR    = 7;

  // Mode straps {data, clock}
  localparam logic [1:0] STRAP_PAR = 2'b00;
  localparam logic [1:0] STRAP_SER = 2'b10;
  localparam logic [1:0] STRAP_INC = 2'b11;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  typedef enum logic [2:0] {
    MODE_PAR = 3'b001,
    MODE_SER = 3'b010,
    MODE_INC = 3'b100
  } mode_e;
endpackage : interp_pkg

// File: sim/interpolator_position_output_tb.sv
/*
  Self-checking bench for the interpolator output block.
  Assumes a 250 MHz clock, the 8-bit register port and the far-side
  quadrature counter model.
*/
module interpolator_position_output_tb
  import interp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       core_clk = 1'b0;
  logic       reset, cmp_up, cmp_down, undervolt_in, gate_run;
  logic       sda_in, scl_in, gate_level, mfp_out, mfp_oe, mfp_wire;
  logic       err_out, err_oe, reg_wr, reg_rd;
  logic [7:0] data_out, data_oe, reg_wdata, reg_rdata;
  logic [3:0] reg_addr;
  int         pcount, min_gap, xor_bad, cycles;
  int         errors = 0;
  int         total_checks = 0;

  always #2 core_clk = ~core_clk;
  // Open-drain style pin: block wins while it drives
  assign mfp_wire = mfp_oe ? mfp_out : gate_level;

  interpolator_position_output u_interpolator_position_output (
    .core_clk(core_clk), .reset(reset), .cmp_up(cmp_up),
    .cmp_down(cmp_down), .seg_in(3'h0), .index_in(1'b0),
    .undervolt_in(undervolt_in), .sda_in(sda_in), .scl_in(scl_in),
    .multi_function_pin_in(mfp_wire), .multi_function_pin_out(mfp_out),
    .multi_function_pin_oe(mfp_oe), .error_out_low_out(err_out),
    .error_out_low_oe(err_oe), .data_out(data_out), .data_oe(data_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  quad_counter_model u_quad_counter_model (
    .core_clk(core_clk), .reset(reset), .data_out(data_out),
    .data_oe(data_oe), .gate_run(gate_run), .sda_in(sda_in),
    .scl_in(scl_in), .gate_level(gate_level), .count(pcount),
    .min_gap(min_gap), .xor_bad(xor_bad));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8

  task automatic check_ok(input logic ok);
    check8({7'h0, ok}, 8'h01);
  endtask : check_ok

  function automatic int sdiff(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    d = a - b;
    return int'(signed'(d));
  endfunction : sdiff

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic pulse(input logic up, input int idle);
    @(posedge core_clk);
    cmp_up   <= up;
    cmp_down <= !up;
    // Four cycles clears the input filter for one or two steps
    repeat (4) @(posedge core_clk);
    cmp_up   <= 1'b0;
    cmp_down <= 1'b0;
    repeat (idle) @(posedge core_clk);
  endtask : pulse

  task automatic t_reset();
    logic [7:0] v;
    reg_read(ADDR_CONFIG, v);
    check8(v, CONFIG_RESET);
    @(posedge core_clk);
    #1 check8(reg_rdata, 8'h00);
    reg_read(ADDR_CTRL, v);
    check8(v, 8'h00);
    reg_read(ADDR_STATUS, v);
    check8({5'h0, v[2:0]}, {5'h0, MODE_INC});
    reg_read(4'hd, v);
    check8(v, 8'h00);
    check8(data_oe, 8'hff);
  endtask : t_reset

  task automatic t_settle();
    logic [7:0] a0, a1;
    reg_read(ADDR_ANGLE, a0);
    repeat (300) @(posedge core_clk);
    reg_read(ADDR_ANGLE, a1);
    check8(a1, a0);
  endtask : t_settle

  task automatic t_undervolt();
    logic [7:0] v;
    undervolt_in <= 1'b1;
    repeat (10) @(posedge core_clk);
    undervolt_in <= 1'b0;
    repeat (10) @(posedge core_clk);
    check_ok(err_oe);
    reg_read(ADDR_ERR, v);
    check8(v, 8'h01);
    reg_write(ADDR_ERR, 8'h01);
    reg_read(ADDR_ERR, v);
    check8(v, 8'h00);
    repeat (3) @(posedge core_clk);
    check_ok(!err_oe);
  endtask : t_undervolt

  task automatic t_track(input logic up, input int n);
    logic [7:0] a0, a1, v;
    int p0, d;
    reg_read(ADDR_ANGLE, a0);
    p0 = pcount;
    repeat (n) pulse(up, 400);
    reg_read(ADDR_ANGLE, a1);
    d = up ? sdiff(a1, a0) : sdiff(a0, a1);
    check_ok(d >= n && d <= 2 * n);
    check_ok(pcount - p0 == sdiff(a1, a0));
    check8(data_out[1:0], {a1[1] ^ a1[0], a1[1]});
    check8(data_out[4:3], {a1[7] ^ a1[6], a1[7]});
    check8(data_out[DL_DIR], !up);
    reg_read(ADDR_STATUS, v);
    check8(v[3], !up);
    check_ok(xor_bad == 0);
  endtask : t_track

  task automatic t_fast();
    logic [7:0] v;
    repeat (3) pulse(1'b1, 20);
    reg_read(ADDR_ERR, v);
    check8(v[ERR_OVS], 1'b1);
    repeat (1200) @(posedge core_clk);
    check_ok(err_oe);
    check_ok(min_gap >= EDGE_GAP_INT);
    reg_write(ADDR_ERR, 8'h02);
    reg_read(ADDR_ERR, v);
    check8(v, 8'h00);
  endtask : t_fast

  task automatic t_mfp();
    logic [7:0] v;
    logic seen;
    seen = 1'b0;
    reg_write(ADDR_CTRL, 8'h06);
    repeat (3) @(posedge core_clk);
    check_ok(mfp_oe);
    check_ok(mfp_out);
    reg_read(ADDR_MT0, v);
    check8(v, 8'h00);
    reg_write(ADDR_TGT0, 8'h01);
    repeat (3) @(posedge core_clk);
    check_ok(!mfp_out);
    reg_write(ADDR_CTRL, 8'h02);
    cmp_up <= 1'b1;
    repeat (4) @(posedge core_clk);
    cmp_up <= 1'b0;
    repeat (300) begin
      @(posedge core_clk);
      seen = seen | mfp_out;
    end
    check_ok(seen);
    reg_write(ADDR_CTRL, 8'h00);
    repeat (3) @(posedge core_clk);
    check_ok(!mfp_oe);
  endtask : t_mfp

  task automatic t_zero();
    logic [7:0] a0, v;
    reg_read(ADDR_ANGLE, a0);
    reg_write(ADDR_CONFIG, 8'h18);
    reg_read(ADDR_ANGLE, v);
    check8(v, a0 + 8'h20);
    reg_write(ADDR_CONFIG, 8'h48);
    reg_write(ADDR_ANGLE, 8'h5a);
    reg_read(ADDR_ANGLE, v);
    check8(v, a0 + 8'h80);
    reg_write(ADDR_CONFIG, 8'h88);
    reg_read(ADDR_ANGLE, a0);
    pulse(1'b1, 400);
    reg_read(ADDR_ANGLE, v);
    check_ok(sdiff(a0, v) >= 1 && sdiff(a0, v) <= 2);
  endtask : t_zero

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    cycles = 0;
    reset <= 1'b1;
    cmp_up <= 1'b0;
    cmp_down <= 1'b0;
    undervolt_in <= 1'b0;
    gate_run <= 1'b1;
    reg_addr <= 4'h0;
    reg_wdata <= 8'h00;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    // Straps and the data enables need a few cycles after release
    repeat (12) @(posedge core_clk);
    t_reset();
    $display("reset values done");
    t_settle();
    $display("static settle done");
    t_undervolt();
    $display("undervoltage done");
    t_track(1'b1, 3);
    $display("forward tracks done");
    t_track(1'b0, 1);
    $display("reverse tracks done");
    t_fast();
    $display("overspeed done");
    t_mfp();
    $display("pin output done");
    t_zero();
    $display("zero and invert done");
    finish_test();
  end
endmodule : interpolator_position_output_tb

// File: sim/quad_counter_model.sv
/*
  Far-side model: an incremental counter decoding the fine tracks,
  plus the board's mode straps and the counter gate driver.
  Assumes the block's data lines are registered on core_clk.
*/
module quad_counter_model
  import interp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [7:0] data_out,
  input  wire logic [7:0] data_oe,
  input  wire logic       gate_run,
  output logic            sda_in,
  output logic            scl_in,
  output logic            gate_level,
  output int              count,
  output int              min_gap,
  output int              xor_bad
);
  logic [1:0] prev_idx;
  logic [1:0] idx;
  int         gap;

  // Straps never move, so the mode seen at reset is stable
  assign sda_in     = STRAP_INC[1];
  assign scl_in     = STRAP_INC[0];
  // Low halts the block's period counter
  assign gate_level = gate_run;
  // Gray position: A gives the high half, A^B the step within it
  assign idx = {data_out[DL_A_FINE],
                data_out[DL_A_FINE] ^ data_out[DL_B_FINE]};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      count    <= 0;
      prev_idx <= 2'h0;
      gap      <= 0;
      min_gap  <= 1000000;
      xor_bad  <= 0;
    end else if (data_oe[DL_A_FINE] !== 1'b1) begin
      prev_idx <= idx;
    end else begin
      prev_idx <= idx;
      gap      <= gap + 1;
      if (idx != prev_idx) begin
        gap <= 1;
        if (gap < min_gap) begin
          min_gap <= gap;
        end
      end
      // A skipped state is a lost step; it counts neither way
      if (idx - prev_idx == 2'h1) begin
        count <= count + 1;
      end else if (idx - prev_idx == 2'h3) begin
        count <= count - 1;
      end
      if (data_out[DL_XOR] !==
          (data_out[DL_A_FINE] ^ data_out[DL_B_FINE])) begin
        xor_bad <= xor_bad + 1;
      end
    end
  end
endmodule : quad_counter_model
